// ---- phy_mgmt_pkg.sv ----
/*
  Constants shared by the PHY management block: frame field widths,
  register offsets, register bit positions, reset values and timing.
  Assumes nothing of its surroundings.
*/
package phy_mgmt_pkg;
  localparam int          PREAMBLE_LEN   = 32;
  localparam int          ADDR_W         = 5;
  localparam int          DATA_W         = 16;
  localparam logic [1:0]  START_PAT      = 2'h1;
  localparam logic [1:0]  OP_READ        = 2'h2;
  localparam logic [1:0]  OP_WRITE       = 2'h1;
  localparam logic [4:0]  PHY_ADDR       = 5'h00;

  localparam logic [4:0]  OFF_CONTROL    = 5'h00;
  localparam logic [4:0]  OFF_STATUS     = 5'h01;
  localparam logic [4:0]  OFF_IDENT_HI   = 5'h02;
  localparam logic [4:0]  OFF_IDENT_LO   = 5'h03;
  localparam logic [4:0]  OFF_ADVERTISE  = 5'h04;
  localparam logic [4:0]  OFF_PARTNER    = 5'h05;
  localparam logic [4:0]  OFF_EXPANSION  = 5'h06;
  localparam logic [4:0]  OFF_MIRROR     = 5'h10;
  localparam logic [4:0]  OFF_IRQ_EN     = 5'h11;
  localparam logic [4:0]  OFF_IRQ_STAT   = 5'h12;
  localparam logic [4:0]  OFF_CONFIG     = 5'h13;
  localparam logic [4:0]  OFF_CHIP_STAT  = 5'h14;

  // Bit positions
  localparam int          CS_AN_DONE     = 9;
  localparam int          CS_DUPLEX      = 11;
  localparam int          CS_SPEED       = 12;
  localparam int          ST_LINK        = 2;
  localparam int          ST_AN_DONE     = 5;
  localparam int          ST_CHANGE      = 6;
  localparam int          IE_ENABLE      = 1;
  localparam int          IS_PENDING     = 15;
  localparam int          CTL_RESTART_AN = 9;
  localparam int          CTL_RESET      = 15;

  localparam logic [15:0] CONTROL_RST    = 16'h1000;
  localparam logic [15:0] ADVERTISE_RST  = 16'h01e1;
  localparam logic [15:0] ZERO16         = 16'h0000;
  localparam logic [15:0] STATUS_CAPS    = 16'h7809;

  // Negotiation time, microseconds, at the 8 ns clock
  localparam int          AN_TIME_US     = 100;
  localparam int          CLK_NS         = 8;
  localparam int          AN_CYCLES      = (AN_TIME_US * 1000) / CLK_NS;
  localparam int          ACT_CYCLES     = 1000;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_OPCODE, ST_ADDR, ST_TURN, ST_DATA
  } frame_state_e;
endpackage : phy_mgmt_pkg

// ---- sync_edge.sv ----
/*
  Two-flop synchroniser with rise and fall pulse detection.
  Assumes the input is asynchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module sync_edge (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic async_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~last_ff;
  assign fall_o  = ~sync_ff & last_ff;
endmodule : sync_edge

// ---- activity_stretch.sv ----
/*
  Stretches a short activity level into a visible indicator pulse.
  Assumes a synchronous activity input on ref_clk_i.
*/
`timescale 1ns/1ps
module activity_stretch #(
  parameter int HOLD = phy_mgmt_pkg::ACT_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic act_i,
  output logic      led_ff_o
);
  logic [$clog2(HOLD+1)-1:0] cnt_ff;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cnt_ff   <= '0;
      led_ff_o <= 1'b0;
    end else begin
      if (act_i)
        cnt_ff <= ($clog2(HOLD+1))'(HOLD);
      else if (cnt_ff != '0)
        cnt_ff <= cnt_ff - 1'b1;
      led_ff_o <= act_i | (cnt_ff != '0);
    end
  end
endmodule : activity_stretch

// ---- phy_mgmt_serial_access.sv ----
/*
  Management side of a 10/100 transceiver: serial frame decoder on the
  management clock/data pins, twelve 16-bit registers, negotiation
  result, link-change interrupt and indicator outputs.
  Assumes mdc_i and mdio_i come from another domain and are sampled here;
  mdc is far slower than ref_clk_i. Link events arrive as plain inputs.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Opcode 10 reads a register, 01 writes one.
// - Five-bit device address must be all zeros.
// - Five-bit register offset, valid from zero to 0x14.
// - Writes: two turnaround cycles, then sixteen data bits into the device.
// - Negotiation starts by itself after power-up.
// - Four modes: 100 and 10 Mb/s, full and half duplex.
// - Negotiation done sets chip status bit 9.
// - Chip status bits 11 and 12 report duplex and speed.
// - Active-low interrupt only when enabled in register 0x11.
// - Interrupt on link parameter change or link failure.
// - Twelve status and control registers reachable by management.
// - Indicators: 100 Mb/s, link, transmit and receive activity.
module phy_mgmt_serial_access #(
  parameter int          AN_CYCLES = phy_mgmt_pkg::AN_CYCLES,
  parameter logic [15:0] IDENT_HI  = 16'h0aa5,  // Arbitrary value
  parameter logic [15:0] IDENT_LO  = 16'h5a01   // Arbitrary value
) (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic mdc_i,
  input  wire logic mdio_i,
  output logic      mdio_o,
  output logic      mdio_oe_o,
  output logic      phy_irq_n_o,
  input  wire logic link_up_i,
  input  wire logic partner_100_i,
  input  wire logic partner_full_i,
  input  wire logic tx_act_i,
  input  wire logic rx_act_i,
  output logic      led_speed_o,
  output logic      led_link_o,
  output logic      led_tx_o,
  output logic      led_rx_o
);
  logic mdc_lvl, mdc_rise, mdc_fall;
  logic mdio_lvl;
  logic link_lvl, link_rise, link_fall;
  logic p100_lvl, pfull_lvl;

  sync_edge u_mdc (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .async_i (mdc_i),
    .level_o (mdc_lvl), .rise_o (mdc_rise), .fall_o (mdc_fall));
  sync_edge u_mdio (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .async_i (mdio_i),
    .level_o (mdio_lvl), .rise_o (), .fall_o ());
  sync_edge u_link (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .async_i (link_up_i),
    .level_o (link_lvl), .rise_o (link_rise), .fall_o (link_fall));
  sync_edge u_p100 (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .async_i (partner_100_i),
    .level_o (p100_lvl), .rise_o (), .fall_o ());
  sync_edge u_pfull (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .async_i (partner_full_i),
    .level_o (pfull_lvl), .rise_o (), .fall_o ());

  // Registers
  logic [15:0] control_ff;
  logic [15:0] advertise_ff;
  logic [15:0] mirror_ff;
  logic [15:0] irq_en_ff;
  logic [15:0] config_ff;
  logic        an_done_ff;
  logic        speed_ff;
  logic        duplex_ff;
  logic        change_ff;
  logic [$clog2(AN_CYCLES+1)-1:0] an_cnt_ff;

  // Frame decoder
  phy_mgmt_pkg::frame_state_e state_ff;
  logic [5:0]  cnt_ff;
  logic [1:0]  op_ff;
  logic [4:0]  phy_ff;
  logic [4:0]  reg_ff;
  logic [15:0] shift_ff;
  logic        wr_stb;
  logic        rd_load;

  function automatic logic [15:0] read_reg(input logic [4:0] off);
    case (off)
      phy_mgmt_pkg::OFF_CONTROL:   read_reg = control_ff;
      phy_mgmt_pkg::OFF_STATUS:    read_reg = phy_mgmt_pkg::STATUS_CAPS
        | (16'(link_lvl) << phy_mgmt_pkg::ST_LINK)
        | (16'(an_done_ff) << phy_mgmt_pkg::ST_AN_DONE)
        | (16'(change_ff) << phy_mgmt_pkg::ST_CHANGE);
      phy_mgmt_pkg::OFF_IDENT_HI:  read_reg = IDENT_HI;
      phy_mgmt_pkg::OFF_IDENT_LO:  read_reg = IDENT_LO;
      phy_mgmt_pkg::OFF_ADVERTISE: read_reg = advertise_ff;
      phy_mgmt_pkg::OFF_PARTNER:   read_reg = {7'h00, pfull_lvl, p100_lvl, 7'h01};
      phy_mgmt_pkg::OFF_EXPANSION: read_reg = {15'h0000, an_done_ff};
      phy_mgmt_pkg::OFF_MIRROR:    read_reg = mirror_ff;
      phy_mgmt_pkg::OFF_IRQ_EN:    read_reg = irq_en_ff;
      phy_mgmt_pkg::OFF_IRQ_STAT:  read_reg = 16'(change_ff) << phy_mgmt_pkg::IS_PENDING;
      phy_mgmt_pkg::OFF_CONFIG:    read_reg = config_ff;
      phy_mgmt_pkg::OFF_CHIP_STAT: read_reg =
          (16'(an_done_ff) << phy_mgmt_pkg::CS_AN_DONE)
        | (16'(duplex_ff)  << phy_mgmt_pkg::CS_DUPLEX)
        | (16'(speed_ff)   << phy_mgmt_pkg::CS_SPEED);
      default:                     read_reg = phy_mgmt_pkg::ZERO16;
    endcase
  endfunction : read_reg

  // Bits are taken on the rising management clock, driven after the falling one
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_ff <= phy_mgmt_pkg::ST_IDLE;
      cnt_ff   <= '0;
      op_ff    <= '0;
      phy_ff   <= '0;
      reg_ff   <= '0;
    end else if (mdc_rise) begin
      case (state_ff)
        phy_mgmt_pkg::ST_IDLE: begin
          if (!mdio_lvl && cnt_ff >= 6'(phy_mgmt_pkg::PREAMBLE_LEN)) begin
            state_ff <= phy_mgmt_pkg::ST_START;
          end
          cnt_ff <= mdio_lvl ? ((cnt_ff == 6'h3f) ? cnt_ff : cnt_ff + 6'h01) : 6'h00;
        end
        phy_mgmt_pkg::ST_START: begin
          state_ff <= mdio_lvl ? phy_mgmt_pkg::ST_OPCODE : phy_mgmt_pkg::ST_IDLE;
          cnt_ff   <= '0;
        end
        phy_mgmt_pkg::ST_OPCODE: begin
          op_ff  <= {op_ff[0], mdio_lvl};
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == 6'h01) begin
            state_ff <= phy_mgmt_pkg::ST_ADDR;
            cnt_ff   <= '0;
          end
        end
        phy_mgmt_pkg::ST_ADDR: begin
          {phy_ff, reg_ff} <= {phy_ff[3:0], reg_ff, mdio_lvl};
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == 6'(2*phy_mgmt_pkg::ADDR_W - 1)) begin
            state_ff <= phy_mgmt_pkg::ST_TURN;
            cnt_ff   <= '0;
          end
        end
        phy_mgmt_pkg::ST_TURN: begin
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == 6'h01) begin
            state_ff <= phy_mgmt_pkg::ST_DATA;
            cnt_ff   <= '0;
          end
        end
        phy_mgmt_pkg::ST_DATA: begin
          cnt_ff <= cnt_ff + 6'h01;
          if (cnt_ff == 6'(phy_mgmt_pkg::DATA_W - 1)) begin
            state_ff <= phy_mgmt_pkg::ST_IDLE;
            cnt_ff   <= '0;
          end
        end
        default: state_ff <= phy_mgmt_pkg::ST_IDLE;
      endcase
    end
  end

  // Frames for another device address are skipped silently; an unknown opcode writes and drives nothing but still clears the change flag at 0x01 or 0x12
  logic ours;
  assign ours    = (phy_ff == phy_mgmt_pkg::PHY_ADDR);
  assign wr_stb  = mdc_rise && state_ff == phy_mgmt_pkg::ST_DATA && ours &&
                   op_ff == phy_mgmt_pkg::OP_WRITE &&
                   cnt_ff == 6'(phy_mgmt_pkg::DATA_W - 1);
  assign rd_load = mdc_fall && state_ff == phy_mgmt_pkg::ST_TURN && cnt_ff == 6'h01;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      shift_ff <= '0;
    end else if (mdc_rise && state_ff == phy_mgmt_pkg::ST_DATA &&
                 op_ff == phy_mgmt_pkg::OP_WRITE) begin
      shift_ff <= {shift_ff[14:0], mdio_lvl};
    end else if (rd_load) begin
      shift_ff <= read_reg(reg_ff);
    end else if (mdc_fall && state_ff == phy_mgmt_pkg::ST_DATA &&
                 op_ff == phy_mgmt_pkg::OP_READ && cnt_ff != 6'h00) begin
      shift_ff <= {shift_ff[14:0], 1'b0};
    end
  end

  // Data line driver: changes only after falling clock edges
  logic rd_frame;
  assign rd_frame = ours && op_ff == phy_mgmt_pkg::OP_READ;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mdio_oe_o <= 1'b0;
      mdio_o    <= 1'b0;
    end else if (mdc_fall) begin
      if (rd_frame && state_ff == phy_mgmt_pkg::ST_TURN && cnt_ff == 6'h01) begin
        mdio_oe_o <= 1'b1;
        mdio_o    <= 1'b0;
      end else if (rd_frame && state_ff == phy_mgmt_pkg::ST_DATA) begin
        mdio_oe_o <= 1'b1;
        mdio_o    <= (cnt_ff == 6'h00) ? shift_ff[15] : shift_ff[14];
      end else begin
        mdio_oe_o <= 1'b0;
        mdio_o    <= 1'b0;
      end
    end
  end

  // Writable registers; reset bit self-clears
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || (control_ff[phy_mgmt_pkg::CTL_RESET])) begin
      control_ff   <= phy_mgmt_pkg::CONTROL_RST;
      advertise_ff <= phy_mgmt_pkg::ADVERTISE_RST;
      mirror_ff    <= phy_mgmt_pkg::ZERO16;
      irq_en_ff    <= phy_mgmt_pkg::ZERO16;
      config_ff    <= phy_mgmt_pkg::ZERO16;
    end else if (wr_stb) begin
      case (reg_ff)
        phy_mgmt_pkg::OFF_CONTROL:   control_ff   <= {shift_ff[14:0], mdio_lvl};
        phy_mgmt_pkg::OFF_ADVERTISE: advertise_ff <= {shift_ff[14:0], mdio_lvl};
        phy_mgmt_pkg::OFF_MIRROR:    mirror_ff    <= {shift_ff[14:0], mdio_lvl};
        phy_mgmt_pkg::OFF_IRQ_EN:    irq_en_ff    <= {shift_ff[14:0], mdio_lvl};
        phy_mgmt_pkg::OFF_CONFIG:    config_ff    <= {shift_ff[14:0], mdio_lvl};
        default: ;
      endcase
    end else begin
      control_ff[phy_mgmt_pkg::CTL_RESTART_AN] <= 1'b0;
    end
  end

  // Negotiation: starts from reset with no command, restarts on link loss
  logic restart;
  logic an_last;
  assign restart = link_fall || control_ff[phy_mgmt_pkg::CTL_RESTART_AN];
  assign an_last = (an_cnt_ff == ($clog2(AN_CYCLES+1))'(AN_CYCLES - 1));
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || restart) begin
      an_cnt_ff  <= '0;
      an_done_ff <= 1'b0;
    end else if (link_lvl && !an_done_ff) begin
      an_cnt_ff <= an_cnt_ff + 1'b1;
      if (an_last)
        an_done_ff <= 1'b1;
    end
  end

  // Take the mode straight from the partner inputs; advertise_ff is not consulted
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      speed_ff  <= 1'b0;
      duplex_ff <= 1'b0;
    end else if (link_lvl && !an_done_ff) begin
      speed_ff  <= p100_lvl;
      duplex_ff <= pfull_lvl;
    end
  end

  // Change flag: set on completion or loss; cleared by reading status, set wins
  logic st_read;
  assign st_read = rd_load && ours && (reg_ff == phy_mgmt_pkg::OFF_STATUS ||
                                       reg_ff == phy_mgmt_pkg::OFF_IRQ_STAT);
  logic an_done_d;
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      change_ff <= 1'b0;
      an_done_d <= 1'b0;
    end else begin
      an_done_d <= an_done_ff;
      if (link_fall || (an_done_ff && !an_done_d))
        change_ff <= 1'b1;
      else if (st_read)
        change_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i)
      phy_irq_n_o <= 1'b1;
    else
      phy_irq_n_o <= ~(change_ff & irq_en_ff[phy_mgmt_pkg::IE_ENABLE]);
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      led_speed_o <= 1'b0;
      led_link_o  <= 1'b0;
    end else begin
      led_speed_o <= an_done_ff & speed_ff;
      led_link_o  <= link_lvl;
    end
  end

  activity_stretch u_tx (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .act_i (tx_act_i), .led_ff_o (led_tx_o));
  activity_stretch u_rx (
    .ref_clk_i (ref_clk_i), .reset_i (reset_i), .act_i (rx_act_i), .led_ff_o (led_rx_o));

  // Checks
  a_irq_needs_enable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    !phy_irq_n_o |-> $past(irq_en_ff[phy_mgmt_pkg::IE_ENABLE]))
    else $error("interrupt asserted while disabled");
  a_link_loss_irq: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    link_fall && irq_en_ff[phy_mgmt_pkg::IE_ENABLE] |->
    ##1 change_ff ##1 (!phy_irq_n_o || !$past(irq_en_ff[phy_mgmt_pkg::IE_ENABLE])))
    else $error("link loss did not raise interrupt");
  a_drive_only_read: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    mdio_oe_o |-> op_ff == phy_mgmt_pkg::OP_READ && ours)
    else $error("data line driven outside a read");
  a_an_done_bit: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(an_done_ff) |-> $past(an_last) && $past(link_lvl))
    else $error("negotiation completed before its count ran out");
  a_turn_release: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    rd_load |-> !mdio_oe_o)
    else $error("data line driven in first turnaround bit");
  a_speed_led: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    led_speed_o |-> $past(speed_ff && an_done_ff))
    else $error("speed indicator without 100 Mb/s result");
  c_read_frame: cover property (@(posedge ref_clk_i) rd_load && rd_frame);
  c_write_frame: cover property (@(posedge ref_clk_i) wr_stb);
  c_irq: cover property (@(posedge ref_clk_i) !phy_irq_n_o);
endmodule : phy_mgmt_serial_access

// ---- mgmt_host_model.sv ----
/*
  Behavioural host controller on the far side of the management pins:
  makes the management clock by toggling, shifts frames out and samples
  read data. Assumes the bench resolves the shared data line with a
  pull-up and feeds the level back on line_i.
*/
`timescale 1ns/1ps
module mgmt_host_model (
  input  wire logic ref_clk_i,
  input  wire logic line_i,
  output logic      mdc_o,
  output logic      data_o,
  output logic      drive_o
);
  initial begin
    mdc_o   = 1'b0;
    data_o  = 1'b1;
    drive_o = 1'b0;
  end

  // One bit per 64 ns clock period; the clock stands low between frames
  task automatic bit_cycle(input logic d, input logic drv, output logic smp);
    @(negedge ref_clk_i);
    drive_o = drv;
    data_o  = d;
    repeat (3) @(negedge ref_clk_i);
    mdc_o = 1'b1;
    @(negedge ref_clk_i);
    // Sampled just after the rise, while the device still holds the bit
    smp = line_i;
    repeat (3) @(negedge ref_clk_i);
    mdc_o = 1'b0;
  endtask : bit_cycle

  // Last 18 bits are sent only for writes; otherwise the line is released
  task automatic frame(input logic [1:0] op, input logic [4:0] dev,
                       input logic [4:0] off, input logic [15:0] wd,
                       output logic [17:0] rd);
    logic [63:0] bits;
    logic        s;
    bits = {32'hffffffff, phy_mgmt_pkg::START_PAT, op, dev, off, 2'h2, wd};
    for (int i = 63; i >= 0; i--) begin
      bit_cycle(bits[i], (i > 17) || (op == phy_mgmt_pkg::OP_WRITE), s);
      if (i <= 17) begin
        rd[i] = s;
      end
    end
    drive_o = 1'b0;
  endtask : frame
endmodule : mgmt_host_model

// ---- phy_mgmt_serial_access_tb.sv ----
/*
  Self-checking bench for the management block: register access through
  serial frames, refused frames, negotiation results, interrupt and
  indicators. Assumes the host model and the design files are compiled
  first.
*/
`timescale 1ns/1ps
module phy_mgmt_serial_access_tb;
  localparam int          AN = 20;
  localparam logic [15:0] ID_HI = 16'h3c11; // Arbitrary value
  localparam logic [15:0] ID_LO = 16'h0c77; // Arbitrary value

  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        link_up_i = 1'b0;
  logic        partner_100_i = 1'b0;
  logic        partner_full_i = 1'b0;
  logic        tx_act_i = 1'b0;
  logic        rx_act_i = 1'b0;
  logic        mdc, host_d, host_drv, dut_d, dut_oe, line;
  logic        phy_irq_n_o, led_speed_o, led_link_o, led_tx_o, led_rx_o;
  logic [17:0] v;
  logic [15:0] d;
  logic [1:0]  op_mode_reg;
  int          mismatches = 0;
  int          n_compared = 0;

  always #4 ref_clk_i = ~ref_clk_i;

  // Pull-up on the shared line when nobody drives it
  assign line = dut_oe ? dut_d : (host_drv ? host_d : 1'b1);

  mgmt_host_model host (
    .ref_clk_i (ref_clk_i),
    .line_i    (line),
    .mdc_o     (mdc),
    .data_o    (host_d),
    .drive_o   (host_drv)
  );

  phy_mgmt_serial_access #(.AN_CYCLES(AN), .IDENT_HI(ID_HI), .IDENT_LO(ID_LO)) dut (
    .ref_clk_i      (ref_clk_i),
    .reset_i        (reset_i),
    .mdc_i          (mdc),
    .mdio_i         (line),
    .mdio_o         (dut_d),
    .mdio_oe_o      (dut_oe),
    .phy_irq_n_o    (phy_irq_n_o),
    .link_up_i      (link_up_i),
    .partner_100_i  (partner_100_i),
    .partner_full_i (partner_full_i),
    .tx_act_i       (tx_act_i),
    .rx_act_i       (rx_act_i),
    .led_speed_o    (led_speed_o),
    .led_link_o     (led_link_o),
    .led_tx_o       (led_tx_o),
    .led_rx_o       (led_rx_o)
  );

  function automatic logic [15:0] an_exp(input logic s, input logic f);
    return (16'(s) << phy_mgmt_pkg::CS_SPEED) | (16'(f) << phy_mgmt_pkg::CS_DUPLEX)
           | (16'h0001 << phy_mgmt_pkg::CS_AN_DONE);
  endfunction : an_exp

  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [4:0] off, input logic [15:0] wd);
    logic [17:0] r;
    host.frame(phy_mgmt_pkg::OP_WRITE, phy_mgmt_pkg::PHY_ADDR, off, wd, r);
  endtask : wr

  // Read and compare the masked bits; the turnaround must read back 1 then 0
  task automatic rdm(input logic [4:0] off, input logic [15:0] m, input logic [15:0] exp);
    logic [17:0] r;
    host.frame(phy_mgmt_pkg::OP_READ, phy_mgmt_pkg::PHY_ADDR, off, 16'h0000, r);
    check({r[17:16], r[15:0] & m}, {2'h2, exp & m});
  endtask : rdm

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : wait_clk

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    wait_clk(50000);
    mismatches++;
    give_verdict();
  end

  initial begin
    void'($urandom(62299));
    wait_clk(8);
    reset_i = 1'b0;
    check(18'(phy_irq_n_o), 18'h1);
    check(18'(dut_oe), 18'h0);
    rdm(phy_mgmt_pkg::OFF_CONTROL, 16'hffff, phy_mgmt_pkg::CONTROL_RST);
    rdm(phy_mgmt_pkg::OFF_ADVERTISE, 16'hffff, phy_mgmt_pkg::ADVERTISE_RST);
    rdm(phy_mgmt_pkg::OFF_IDENT_HI, 16'hffff, ID_HI);
    rdm(phy_mgmt_pkg::OFF_IDENT_LO, 16'hffff, ID_LO);
    for (int i = 0; i < 4; i++) begin
      d = 16'($urandom);
      wr(phy_mgmt_pkg::OFF_MIRROR, d);
      rdm(phy_mgmt_pkg::OFF_MIRROR, 16'hffff, d);
    end
    wr(phy_mgmt_pkg::OFF_ADVERTISE, ~phy_mgmt_pkg::ADVERTISE_RST);
    rdm(phy_mgmt_pkg::OFF_ADVERTISE, 16'hffff, ~phy_mgmt_pkg::ADVERTISE_RST);
    wr(phy_mgmt_pkg::OFF_IDENT_HI, ~ID_HI);
    rdm(phy_mgmt_pkg::OFF_IDENT_HI, 16'hffff, ID_HI);
    wr(5'h15, 16'hffff);
    rdm(5'h15, 16'hffff, 16'h0000);
    rdm(5'h08, 16'hffff, 16'h0000);
    host.frame(phy_mgmt_pkg::OP_WRITE, 5'h01, phy_mgmt_pkg::OFF_MIRROR, ~d, v);
    rdm(phy_mgmt_pkg::OFF_MIRROR, 16'hffff, d);
    host.frame(2'h3, phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::OFF_MIRROR, ~d, v);
    check(v, 18'h3ffff);
    host.frame(phy_mgmt_pkg::OP_READ, 5'h1f, phy_mgmt_pkg::OFF_MIRROR, 16'h0000, v);
    check(v, 18'h3ffff);
    // Soft reset through the control register restores the writable set
    wr(phy_mgmt_pkg::OFF_CONTROL, 16'h8000);
    rdm(phy_mgmt_pkg::OFF_ADVERTISE, 16'hffff, phy_mgmt_pkg::ADVERTISE_RST);
    wr(phy_mgmt_pkg::OFF_IRQ_EN, 16'h0000);
    rdm(phy_mgmt_pkg::OFF_CHIP_STAT, an_exp(1'b1, 1'b1), 16'h0000);
    for (int m = 0; m < 4; m++) begin
      link_up_i = 1'b0;
      wait_clk(10);
      partner_100_i = m[1];
      partner_full_i = m[0];
      link_up_i = 1'b1;
      wait_clk(AN + 20);
      rdm(phy_mgmt_pkg::OFF_CHIP_STAT, an_exp(1'b1, 1'b1), an_exp(m[1], m[0]));
      // Host copies the resolved mode into its own operation mode register
      host.frame(phy_mgmt_pkg::OP_READ, phy_mgmt_pkg::PHY_ADDR, phy_mgmt_pkg::OFF_CHIP_STAT,
                 16'h0000, v);
      op_mode_reg = {v[phy_mgmt_pkg::CS_SPEED], v[phy_mgmt_pkg::CS_DUPLEX]};
      check(18'(op_mode_reg), 18'(m[1:0]));
      check({led_speed_o, led_link_o}, {1'b0, m[1], 1'b1});
      check(18'(phy_irq_n_o), 18'h1);
    end
    rdm(phy_mgmt_pkg::OFF_STATUS, 16'h0000, 16'h0000);
    wr(phy_mgmt_pkg::OFF_IRQ_EN, 16'h0001 << phy_mgmt_pkg::IE_ENABLE);
    check(18'(phy_irq_n_o), 18'h1);
    link_up_i = 1'b0;
    wait_clk(20);
    check({phy_irq_n_o, led_link_o}, 18'h0);
    d = (16'h0001 << phy_mgmt_pkg::ST_CHANGE) | (16'h0001 << phy_mgmt_pkg::ST_LINK);
    rdm(phy_mgmt_pkg::OFF_STATUS, d, 16'h0001 << phy_mgmt_pkg::ST_CHANGE);
    wait_clk(10);
    check(18'(phy_irq_n_o), 18'h1);
    // Single-cycle activity must be stretched to a visible pulse
    for (int j = 0; j < 2; j++) begin
      {tx_act_i, rx_act_i} = j[0] ? 2'b01 : 2'b10;
      wait_clk(1);
      {tx_act_i, rx_act_i} = 2'b00;
      wait_clk(6);
      check({led_tx_o, led_rx_o}, j[0] ? 18'h1 : 18'h2);
      wait_clk(phy_mgmt_pkg::ACT_CYCLES + 20);
      check({led_tx_o, led_rx_o}, 18'h0);
    end
    give_verdict();
  end
endmodule : phy_mgmt_serial_access_tb
